// File: design/csr_defs.vh
/*
 Constants for the CPU status and operand register block.
 Assumes inclusion by bare name from design and bench files.
*/
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH
`define CSR_OFF_STATUS 8'hD0
`define CSR_OFF_MAIN 8'hE0
`define CSR_OFF_AUX 8'hF0
`define CSR_OFF_ALU 8'h40
`define CSR_OFF_AUX_OP 8'h44
`define CSR_OFF_BANK 8'h48
`define CSR_MAIN_RST 8'h00
`define CSR_AUX_RST 8'h00
`define CSR_STATUS_RST 8'h00
`define CSR_BIT_CARRY 7
`define CSR_BIT_HALF 6
`define CSR_BIT_USER0 5
`define CSR_BIT_BANK_HI 4
`define CSR_BIT_BANK_LO 3
`define CSR_BIT_OVER 2
`define CSR_BIT_USER1 1
`define CSR_BIT_PARITY 0
`define CSR_OP_ADD 3'h0
`define CSR_OP_ADDC 3'h1
`define CSR_OP_SUBB 3'h2
`define CSR_OP_RLC 3'h3
`define CSR_OP_RRC 3'h4
`define CSR_OP_CMP 3'h5
`define CSR_OP_DA 3'h6
`define CSR_OP_MUL 3'h7
`define CSR_RESP_OKAY 2'h0
`define CSR_RESP_SLVERR 2'h2
`endif

// File: design/csr_alu.v
/*
 Combinational arithmetic unit: result and flag updates for one operation.
 Assumes the caller registers the outputs.
*/
`timescale 1ns/1ps
`include "csr_defs.vh"
module csr_alu (
    input wire [2:0] op_i,
    input wire [7:0] lhs_i,
    input wire [7:0] rhs_i,
    input wire carry_i,
    input wire half_i,
    input wire over_i,
    output reg [7:0] res_o,
    output reg [7:0] aux_res_o,
    output reg aux_we_o,
    output reg main_we_o,
    output reg carry_o,
    output reg half_o,
    output reg over_o
);
    reg [8:0] sum;
    reg [4:0] low;
    reg [8:0] adj;
    reg [15:0] prod;
    always @* begin
        sum = 9'h000;
        low = 5'h00;
        adj = 9'h000;
        prod = 16'h0000;
        res_o = lhs_i;
        aux_res_o = rhs_i;
        aux_we_o = 1'b0;
        main_we_o = 1'b1;
        carry_o = carry_i;
        half_o = half_i;
        over_o = over_i;
        case (op_i)
            `CSR_OP_ADD, `CSR_OP_ADDC: begin
                sum = {1'b0, lhs_i} + {1'b0, rhs_i} + {8'h00, (op_i == `CSR_OP_ADDC) & carry_i};
                low = {1'b0, lhs_i[3:0]} + {1'b0, rhs_i[3:0]} + {4'h0, (op_i == `CSR_OP_ADDC) & carry_i};
                res_o = sum[7:0];
                carry_o = sum[8];
                half_o = low[4];
                over_o = (lhs_i[7] == rhs_i[7]) && (sum[7] != lhs_i[7]);
            end
            `CSR_OP_SUBB, `CSR_OP_CMP: begin
                sum = {1'b0, lhs_i} - {1'b0, rhs_i} - {8'h00, (op_i == `CSR_OP_SUBB) & carry_i};
                low = {1'b0, lhs_i[3:0]} - {1'b0, rhs_i[3:0]} - {4'h0, (op_i == `CSR_OP_SUBB) & carry_i};
                res_o = sum[7:0];
                main_we_o = (op_i == `CSR_OP_SUBB);
                // Carry set when no borrow, i.e. result at or above zero
                carry_o = ~sum[8];
                if (op_i == `CSR_OP_SUBB) begin
                    half_o = low[4];
                    over_o = (lhs_i[7] != rhs_i[7]) && (sum[7] != lhs_i[7]);
                end
            end
            `CSR_OP_RLC: begin
                res_o = {lhs_i[6:0], carry_i};
                carry_o = lhs_i[7];
            end
            `CSR_OP_RRC: begin
                res_o = {carry_i, lhs_i[7:1]};
                carry_o = lhs_i[0];
            end
            `CSR_OP_DA: begin
                adj = {1'b0, lhs_i};
                if ((lhs_i[3:0] > 4'h9) || half_i) begin
                    adj = adj + 9'h006;
                end
                low = {1'b0, lhs_i[3:0]} + 5'h06;
                half_o = ((lhs_i[3:0] > 4'h9) || half_i) ? low[4] : 1'b0;
                if ((adj[7:4] > 4'h9) || adj[8] || carry_i) begin
                    adj = adj + 9'h060;
                end
                res_o = adj[7:0];
                carry_o = adj[8] | carry_i;
            end
            `CSR_OP_MUL: begin
                prod = {8'h00, lhs_i} * {8'h00, rhs_i};
                res_o = prod[7:0];
                aux_res_o = prod[15:8];
                aux_we_o = 1'b1;
                carry_o = 1'b0;
                over_o = (prod[15:8] != 8'h00);
            end
            default: begin
                main_we_o = 1'b0;
            end
        endcase
    end
endmodule

// File: design/csr_regs.v
/*
 Accumulator, auxiliary operand and status word register block with an
 AXI4-Lite slave and a one-cycle ALU operation port.
 Assumes one clock; ALU requests are synchronous and one per cycle.
*/
`timescale 1ns/1ps
`include "csr_defs.vh"
// What this block does
// - An 8-bit read/write main operand register resets to 0x00.
// - Operations on the main operand register update the matching status flags.
// - An 8-bit read/write auxiliary operand register resets to 0x00 and takes the multiply high byte.
// - Status bit 7 is carry: set on add carry-out, no borrow, rotated-out one or compare at or above zero.
// - Status bit 6 is half-carry: carry or borrow out of bit 3 on add, subtract with borrow and decimal adjust; other operations keep it.
// - Status bits 5 and 1 are user flags that only software changes.
// - Status bits 4:3 pick the working bank at base 00H, 08H, 10H or 18H.
// - Status bit 2 is overflow: add, subtract with borrow and multiply set or clear it; other operations keep it.
// - Status bit 0 is read-only parity, one for an odd count of ones in the main operand register.
module csr_regs (
    input wire clk_i,
    input wire nrst_i,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire alu_valid_i,
    input wire [2:0] alu_op_i,
    input wire [7:0] alu_operand_i,
    output reg [7:0] main_operand_o,
    output reg [7:0] program_status_word_o,
    output reg [4:0] bank_base_o
);
    reg [7:0] main_operand_reg;
    reg [7:0] aux_operand_reg;
    reg carry_flag;
    reg half_carry_flag;
    reg user_flag_zero;
    reg [1:0] bank_select;
    reg overflow_flag;
    reg user_flag_one;
    reg use_aux;
    reg [2:0] last_op;
    reg [7:0] aw_addr;
    reg aw_have;
    reg [7:0] w_data;
    reg w_have;
    wire parity_flag;
    wire [7:0] status_view;
    wire [7:0] alu_res;
    wire [7:0] alu_aux_res;
    wire alu_aux_we;
    wire alu_main_we;
    wire alu_carry;
    wire alu_half;
    wire alu_over;
    wire rd_hit;
    reg s_axi_wstrb_ok;
    reg [7:0] next_main;
    reg [7:0] rd_byte;

    function map_hit;
        input [7:0] addr;
        begin
            map_hit = (addr == `CSR_OFF_STATUS) || (addr == `CSR_OFF_MAIN) || (addr == `CSR_OFF_AUX) ||
                (addr == `CSR_OFF_ALU) || (addr == `CSR_OFF_AUX_OP) || (addr == `CSR_OFF_BANK);
        end
    endfunction

    assign parity_flag = ^main_operand_reg;
    assign status_view = {carry_flag, half_carry_flag, user_flag_zero, bank_select,
        overflow_flag, user_flag_one, parity_flag};

    csr_alu u_alu (
        .op_i(alu_op_i),
        .lhs_i(main_operand_reg),
        .rhs_i(use_aux ? aux_operand_reg : alu_operand_i),
        .carry_i(carry_flag),
        .half_i(half_carry_flag),
        .over_i(overflow_flag),
        .res_o(alu_res),
        .aux_res_o(alu_aux_res),
        .aux_we_o(alu_aux_we),
        .main_we_o(alu_main_we),
        .carry_o(alu_carry),
        .half_o(alu_half),
        .over_o(alu_over)
    );

    assign rd_hit = map_hit(s_axi_araddr);

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CSR_RESP_OKAY;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 8'h00;
        end else begin
            // Each channel is taken on its own; the pair commits once both are held
            s_axi_awready <= ~aw_have & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_have & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata[7:0];
            end
            if (aw_have & w_have & ~s_axi_bvalid) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= map_hit(aw_addr) ? `CSR_RESP_OKAY : `CSR_RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register updates: a software write takes priority over an ALU result
    always @* begin
        next_main = main_operand_reg;
        if (alu_valid_i & alu_main_we) begin
            next_main = alu_res;
        end
        if (aw_have & w_have & ~s_axi_bvalid & s_axi_wstrb_ok & (aw_addr == `CSR_OFF_MAIN)) begin
            next_main = w_data;
        end
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_axi_wstrb_ok <= 1'b0;
        end else if (s_axi_wvalid & s_axi_wready) begin
            s_axi_wstrb_ok <= s_axi_wstrb[0];
        end
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            main_operand_reg <= `CSR_MAIN_RST;
            aux_operand_reg <= `CSR_AUX_RST;
            carry_flag <= 1'b0;
            half_carry_flag <= 1'b0;
            user_flag_zero <= 1'b0;
            bank_select <= 2'h0;
            overflow_flag <= 1'b0;
            user_flag_one <= 1'b0;
            use_aux <= 1'b0;
            last_op <= 3'h0;
        end else begin
            main_operand_reg <= next_main;
            if (alu_valid_i) begin
                last_op <= alu_op_i;
                carry_flag <= alu_carry;
                half_carry_flag <= alu_half;
                overflow_flag <= alu_over;
                if (alu_aux_we) begin
                    aux_operand_reg <= alu_aux_res;
                end
            end
            if (aw_have & w_have & ~s_axi_bvalid & s_axi_wstrb_ok) begin
                case (aw_addr)
                    `CSR_OFF_STATUS: begin
                        // Parity bit of the written byte is dropped
                        carry_flag <= w_data[`CSR_BIT_CARRY];
                        half_carry_flag <= w_data[`CSR_BIT_HALF];
                        user_flag_zero <= w_data[`CSR_BIT_USER0];
                        bank_select <= w_data[`CSR_BIT_BANK_HI:`CSR_BIT_BANK_LO];
                        overflow_flag <= w_data[`CSR_BIT_OVER];
                        user_flag_one <= w_data[`CSR_BIT_USER1];
                    end
                    `CSR_OFF_AUX: begin
                        aux_operand_reg <= w_data;
                    end
                    `CSR_OFF_AUX_OP: begin
                        use_aux <= w_data[0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always @* begin
        case (s_axi_araddr)
            `CSR_OFF_STATUS: rd_byte = status_view;
            `CSR_OFF_MAIN: rd_byte = main_operand_reg;
            `CSR_OFF_AUX: rd_byte = aux_operand_reg;
            `CSR_OFF_ALU: rd_byte = {5'h00, last_op};
            `CSR_OFF_AUX_OP: rd_byte = {7'h00, use_aux};
            `CSR_OFF_BANK: rd_byte = {3'h0, bank_select, 3'h0};
            default: rd_byte = 8'h00;
        endcase
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CSR_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_hit ? `CSR_RESP_OKAY : `CSR_RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            main_operand_o <= `CSR_MAIN_RST;
            program_status_word_o <= `CSR_STATUS_RST;
            bank_base_o <= 5'h00;
        end else begin
            main_operand_o <= next_main;
            program_status_word_o <= status_view;
            bank_base_o <= {bank_select, 3'h0};
        end
    end
endmodule

// File: tb/csr_checker.sv
/* Port assertions for csr_regs.
 Assumes binding onto csr_regs and the ALU second operand taken from alu_operand_i. */
`timescale 1ns/1ps
`include "csr_defs.vh"
module csr_checker (
    input wire clk_i,
    input wire nrst_i,
    input wire s_axi_awvalid,
    input wire s_axi_bvalid,
    input wire alu_valid_i,
    input wire [2:0] alu_op_i,
    input wire [7:0] alu_operand_i,
    input wire [7:0] main_operand_o,
    input wire [7:0] program_status_word_o
);
    logic aw_d;
    // No software write may land on the flags around an ALU op
    wire q = !s_axi_awvalid && !aw_d;
    wire [8:0] sum9 = main_operand_o + alu_operand_i;
    wire [7:0] sum8 = sum9[7:0];
    wire c8 = sum9[8];
    wire ovf = (main_operand_o[7] == alu_operand_i[7]) && (sum8[7] != main_operand_o[7]);
    wire add = alu_valid_i && alu_op_i == `CSR_OP_ADD && q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) aw_d <= 1'b0;
        else aw_d <= s_axi_awvalid;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_par; program_status_word_o[0] == ^$past(main_operand_o); endproperty
    a_par: assert property (p_par) else $error("parity bit wrong");
    property p_usr; $changed({program_status_word_o[5], program_status_word_o[1]}) |-> $past(s_axi_bvalid); endproperty
    a_usr: assert property (p_usr) else $error("user flag changed without write");
    property p_bank; $changed(program_status_word_o[4:3]) |-> $past(s_axi_bvalid); endproperty
    a_bank: assert property (p_bank) else $error("bank select changed without write");
    property p_rlc;
        alu_valid_i && alu_op_i == `CSR_OP_RLC && q |-> ##2 program_status_word_o[7] == $past(main_operand_o[7], 2);
    endproperty
    a_rlc: assert property (p_rlc) else $error("rotate carry wrong");
    property p_add; add |=> main_operand_o == $past(sum8); endproperty
    a_add: assert property (p_add) else $error("add result wrong");
    property p_addcy; add |-> ##2 program_status_word_o[7] == $past(c8, 2); endproperty
    a_addcy: assert property (p_addcy) else $error("add carry wrong");
    property p_ov; add |-> ##2 program_status_word_o[2] == $past(ovf, 2); endproperty
    a_ov: assert property (p_ov) else $error("overflow flag wrong");
    property p_cmp; alu_valid_i && alu_op_i == `CSR_OP_CMP && q |=> $stable(main_operand_o); endproperty
    a_cmp: assert property (p_cmp) else $error("compare changed main operand");
    c_add: cover property (add);
    c_rlc: cover property (alu_valid_i && alu_op_i == `CSR_OP_RLC);
    c_wr: cover property (s_axi_bvalid);
endmodule
bind csr_regs csr_checker chk_u (.clk_i, .nrst_i, .s_axi_awvalid, .s_axi_bvalid, .alu_valid_i, .alu_op_i,
    .alu_operand_i, .main_operand_o, .program_status_word_o);

// File: tb/csr_core_model.sv
/* Execution core model: issues one ALU operation per call.
 Assumes clk_i is the block clock; the bench calls issue(). */
`timescale 1ns/1ps
module csr_core_model (
    input wire clk_i,
    output logic alu_valid_o,
    output logic [2:0] alu_op_o,
    output logic [7:0] alu_operand_o
);
    initial begin
        alu_valid_o = 1'b0;
        alu_op_o = 3'h0;
        alu_operand_o = 8'h00;
    end
    task issue(input logic [2:0] op, input logic [7:0] opnd, input int gap);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        alu_valid_o <= 1'b1;
        alu_op_o <= op;
        alu_operand_o <= opnd;
        @(posedge clk_i);
        alu_valid_o <= 1'b0;
        // Idle lines carry junk, not the last operation
        alu_op_o <= ~op;
        alu_operand_o <= ~opnd;
    endtask
endmodule

// File: tb/test_cpu_status_and_operand_regs.sv
/* Self-checking bench for csr_regs over AXI4-Lite and the ALU port.
 Assumes the aux-source control is set only around one multiply. */
`timescale 1ns/1ps
`include "csr_defs.vh"
module test_cpu_status_and_operand_regs;
    logic clk_i, nrst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, alu_valid_i;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0] alu_op_i;
    wire [7:0] alu_operand_i, main_operand_o, program_status_word_o;
    wire [4:0] bank_base_o;
    int n_fail = 0, comparisons = 0, cyc = 0;
    localparam logic [2:0] OPS[11] = '{`CSR_OP_ADD, `CSR_OP_ADD, `CSR_OP_RLC, `CSR_OP_RRC, `CSR_OP_CMP,
        `CSR_OP_ADD, `CSR_OP_MUL, `CSR_OP_ADDC, `CSR_OP_DA, `CSR_OP_SUBB, `CSR_OP_SUBB};
    localparam logic [7:0] OPB[11] = '{8'h01, 8'h80, 8'h00, 8'h00, 8'h01, 8'h20, 8'h10,
        8'h27, 8'h00, 8'h50, 8'h74};
    localparam logic [7:0] EMAIN[11] = '{8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h20, 8'h00,
        8'h3D, 8'h43, 8'hF3, 8'h7F};
    localparam logic [7:0] MSK[11] = '{8'hFF, 8'hFF, 8'hA3, 8'hA3, 8'hA3, 8'hA3, 8'hA3,
        8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [7:0] ESTAT[11] = '{8'h67, 8'hA6, 8'h23, 8'hA2, 8'h22, 8'h23, 8'h22,
        8'h01, 8'h41, 8'h00, 8'hC5};
    csr_regs dut_u (.clk_i, .nrst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .alu_valid_i, .alu_op_i,
        .alu_operand_i, .main_operand_o, .program_status_word_o, .bank_base_o);
    csr_core_model core_u (.clk_i(clk_i), .alu_valid_o(alu_valid_i), .alu_op_o(alu_op_i),
        .alu_operand_o(alu_operand_i));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task print_verdict;
        if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk("rdata", d, e);
        chk("rresp", {30'h0, r}, {30'h0, `CSR_RESP_OKAY});
    endtask
    task t_reset;
        rdc(`CSR_OFF_MAIN, 32'h0);
        rdc(`CSR_OFF_AUX, 32'h0);
        rdc(`CSR_OFF_STATUS, 32'h0);
        chk("bank", {27'h0, bank_base_o}, 32'h0);
    endtask
    task t_regs;
        logic [31:0] d;
        logic [1:0] r;
        wr(`CSR_OFF_AUX, 32'h3C, r);
        rdc(`CSR_OFF_AUX, 32'h3C);
        // A write with byte lane 0 disabled is answered but changes nothing
        s_axi_wstrb <= 4'hE;
        wr(`CSR_OFF_AUX, 32'h99, r);
        s_axi_wstrb <= 4'hF;
        chk("wstrb resp", {30'h0, r}, {30'h0, `CSR_RESP_OKAY});
        rdc(`CSR_OFF_AUX, 32'h3C);
        wr(`CSR_OFF_MAIN, 32'hA5, r);
        rdc(`CSR_OFF_MAIN, 32'hA5);
        wr(`CSR_OFF_STATUS, 32'hFF, r);
        rdc(`CSR_OFF_STATUS, 32'hFE);
        wr(`CSR_OFF_MAIN, 32'h07, r);
        rdc(`CSR_OFF_STATUS, 32'hFF);
        wr(8'h10, 32'h55, r);
        chk("wr resp", {30'h0, r}, {30'h0, `CSR_RESP_SLVERR});
        rd(8'h10, d, r);
        chk("rd resp", {30'h0, r}, {30'h0, `CSR_RESP_SLVERR});
        chk("rd data", d, 32'h0);
    endtask
    task t_bank;
        logic [1:0] r;
        for (int i = 0; i < 4; i++) begin
            wr(`CSR_OFF_STATUS, i << 3, r);
            repeat (3) @(posedge clk_i);
            chk("bank", {27'h0, bank_base_o}, i * 8);
            rdc(`CSR_OFF_STATUS, (i << 3) | 1);
            rdc(`CSR_OFF_BANK, i << 3);
        end
    endtask
    task t_alu;
        logic [1:0] r;
        wr(`CSR_OFF_MAIN, 32'h7F, r);
        wr(`CSR_OFF_STATUS, 32'h22, r);
        for (int i = 0; i < 11; i++) begin
            if (i == 7) begin
                rdc(`CSR_OFF_AUX, 32'h02);
                // Carry in set for the add with carry; user flags cleared
                wr(`CSR_OFF_MAIN, 32'h15, r);
                wr(`CSR_OFF_STATUS, 32'h80, r);
            end
            core_u.issue(OPS[i], OPB[i], i % 3);
            repeat (2) @(posedge clk_i);
            chk("main", {24'h0, main_operand_o}, {24'h0, EMAIN[i]});
            chk("status", {24'h0, program_status_word_o & MSK[i]}, {24'h0, ESTAT[i]});
        end
        rdc(`CSR_OFF_ALU, {29'h0, `CSR_OP_SUBB});
    endtask
    task t_aux;
        logic [1:0] r;
        wr(`CSR_OFF_AUX_OP, 32'h1, r);
        rdc(`CSR_OFF_AUX_OP, 32'h1);
        wr(`CSR_OFF_AUX, 32'h03, r);
        wr(`CSR_OFF_MAIN, 32'h05, r);
        // Port operand must be ignored while the aux source is selected
        core_u.issue(`CSR_OP_MUL, 8'hFF, 0);
        repeat (2) @(posedge clk_i);
        chk("main", {24'h0, main_operand_o}, 32'h0F);
        rdc(`CSR_OFF_AUX, 32'h00);
        rdc(`CSR_OFF_ALU, {29'h0, `CSR_OP_MUL});
        wr(`CSR_OFF_AUX_OP, 32'h0, r);
        rdc(`CSR_OFF_AUX_OP, 32'h0);
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            print_verdict;
        end
    end
    initial begin
        nrst_i = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_reset;
        t_regs;
        t_bank;
        t_alu;
        t_aux;
        print_verdict;
    end
endmodule
